/* File: ihp_host_model.sv */
// Purpose: host processor model driving the port's bus pins
// Assumes: strobes follow pol_high; outputs are read at the falling edge
// Notes: released data lines show the inverse of the last value
`timescale 1ns/1ns
module ihp_host_model (
  // clock and device answers
  input wire logic mclk,
  input wire logic pol_high,
  input wire logic cmd_ready,
  input wire logic rd_oe,
  input wire logic [15:0] rd_lo,
  input wire logic [15:0] rd_hi,
  // host pins
  output logic [5:0] upper_addr,
  output logic addr_qualify_n,
  output logic cmd_type,
  output logic rd_n,
  output logic wr_n,
  output logic [15:0] wd_lo,
  output logic [15:0] wd_hi
);
  logic act_rd; // read strobe asserted
  logic act_wr; // write strobe asserted
  logic saw_wait; // cmd_ready seen low while holding
  // active level follows polarity; a flip still looks like a stray strobe until the pins are synchronised
  assign rd_n = act_rd ? pol_high : !pol_high;
  assign wr_n = act_wr ? pol_high : !pol_high;
  initial begin
    upper_addr = 6'h00;
    addr_qualify_n = 1'b1;
    cmd_type = 1'b0;
    act_rd = 1'b0;
    act_wr = 1'b0;
    wd_lo = 16'h0000;
    wd_hi = 16'h0000;
    saw_wait = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one command: hold until answered, then release and idle
  task automatic cycle(input logic [5:0] a, input logic q_n, input logic cmd,
                       input logic rd, input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    int t;
    n = 0;
    rdat = 32'hFFFF_FFFF;
    saw_wait = 1'b0;
    @(posedge mclk);
    upper_addr <= a;
    addr_qualify_n <= q_n;
    cmd_type <= cmd;
    wd_lo <= wd[15:0];
    wd_hi <= wd[31:16];
    act_rd <= rd;
    act_wr <= !rd;
    for (t = 0; t < 200 && n < 40; t++) begin
      @(negedge mclk);
      // wait while the device holds the command
      if (cmd_ready !== 1'b1) begin
        saw_wait = 1'b1;
      end else begin
        n++;
      end
      if (rd && rd_oe === 1'b1) begin
        rdat = {rd_hi, rd_lo};
        break;
      end
      if (!rd && n >= 10) begin
        break;
      end
    end
    @(posedge mclk);
    act_rd <= 1'b0;
    act_wr <= 1'b0;
    wd_lo <= ~wd[15:0];
    wd_hi <= ~wd[31:16];
    repeat (12) @(posedge mclk);
  endtask
endmodule

/* File: ihp_host_port.sv */
// Purpose: processor-side host port decode, strobes and indications
// Assumes: eeprom settings come from same-clock logic; host pins are async
// Notes: host pins pass a three-stage synchroniser before use
// Notes on behaviour
// - base address is strap times 16 plus 300h
// - select on upper address match, qualify low
// - command type chooses data or index port
// - command ready low while previous command pending
// - hardware reset pin high resets the port
// - strobes active low unless eeprom flips them
// - word indication on 16 or 32 bit access
// - irq polarity from strap, eeprom may flip
// - dword indication on 32 bit access only
// - upper data bits only in dword strap mode
// - access width decoded from wake and eeprom straps
`timescale 1ns/1ns
`include "ihp_params.svh"
module ihp_host_port (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hw_reset,
  // strap pins, sampled after reset
  input wire logic [2:0] base_strap,
  input wire logic int_low_strap,
  input wire logic eeprom_out_strap,
  input wire logic wakeup_strap,
  // host bus
  input wire logic [5:0] upper_addr,
  input wire logic addr_qualify_n,
  input wire logic cmd_type,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic [15:0] host_data_low_i,
  output logic [15:0] host_data_low_o,
  output logic host_data_low_oe,
  input wire logic [15:0] host_data_high_i,
  output logic [15:0] host_data_high_o,
  output logic host_data_high_oe,
  output logic cmd_ready,
  output logic word_access_ind_n,
  output logic dword_access_ind_n,
  output logic irq_out,
  // eeprom settings
  input wire logic strobe_pol_high,
  input wire logic ind_pol_high,
  input wire logic int_pol_flip,
  // core side
  output logic [7:0] reg_index,
  output logic reg_rd,
  output logic reg_wr,
  output logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_busy,
  input wire logic mem_port,
  input wire logic irq_in
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // io base from latched strap value
  function automatic logic [9:0] ihp_io_base(input logic [2:0] s);
    ihp_io_base = `IHP_IO_FIXED + ({7'h00, s} * `IHP_IO_STEP);
  endfunction

  // width decode, reserved code is passed through as IHP_WRSV
  function automatic ihp_pkg::ihp_width_e ihp_width(input logic wk, input logic ed);
    ihp_width = ihp_pkg::ihp_width_e'({wk, ed});
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // synchroniser: stage 1 feeds only stage 2

  logic [`IHP_SY_W-1:0] sy1_r, sy2_r, sy3_r, filt_r; // sync stages
  logic [`IHP_SY_W-1:0] raw, filt_nxt; // pin vector, filtered next
  always_comb begin
    raw = {hw_reset, wakeup_strap, eeprom_out_strap, int_low_strap, base_strap,
           upper_addr, addr_qualify_n, cmd_type, host_write_strobe_n,
           host_read_strobe_n, host_data_high_i, host_data_low_i};
    // a bit moves only when stages 2 and 3 agree
    filt_nxt = ((sy2_r ~^ sy3_r) & sy3_r) | ((sy2_r ^ sy3_r) & filt_r);
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sy1_r <= `IHP_SY_RST;
      sy2_r <= `IHP_SY_RST;
      sy3_r <= `IHP_SY_RST;
      filt_r <= `IHP_SY_RST;
    end else begin
      sy1_r <= raw;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      filt_r <= filt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // decode of filtered pins

  logic hrst; // hardware reset, filtered
  logic rd_act, wr_act, strobe; // strobes after polarity
  logic sel; // chip selected
  logic [31:0] hdata; // host data in
  always_comb begin
    hrst = filt_r[`IHP_B_HWRST];
    rd_act = filt_r[`IHP_B_RD] ^ ~strobe_pol_high;
    wr_act = filt_r[`IHP_B_WR] ^ ~strobe_pol_high;
    strobe = rd_act | wr_act;
    hdata = filt_r[31:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // strap capture: caught after release, again after hw reset

  logic [2:0] base_r, base_nxt; // latched base strap
  logic intlo_r, intlo_nxt; // irq low strap
  logic eed_r, eed_nxt, wake_r, wake_nxt; // width straps
  logic [2:0] settle_r, settle_nxt; // cycles since reset
  logic ready_r, ready_nxt; // straps valid
  always_comb begin
    base_nxt = base_r;
    intlo_nxt = intlo_r;
    eed_nxt = eed_r;
    wake_nxt = wake_r;
    settle_nxt = settle_r;
    ready_nxt = ready_r;
    if (hrst) begin
      settle_nxt = 3'h0;
      ready_nxt = 1'b0;
    end else if (!ready_r) begin
      // wait for the sync pipe to fill, then latch
      if (settle_r == `IHP_SETTLE) begin
        ready_nxt = 1'b1;
        base_nxt = filt_r[`IHP_B_BASE_HI:`IHP_B_BASE_LO];
        intlo_nxt = filt_r[`IHP_B_INTLO];
        eed_nxt = filt_r[`IHP_B_EEDAT];
        wake_nxt = filt_r[`IHP_B_WAKE];
      end else begin
        settle_nxt = settle_r + 3'h1;
      end
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      base_r <= 3'h0;
      intlo_r <= 1'b0;
      eed_r <= 1'b0;
      wake_r <= 1'b0;
      settle_r <= 3'h0;
      ready_r <= 1'b0;
    end else begin
      base_r <= base_nxt;
      intlo_r <= intlo_nxt;
      eed_r <= eed_nxt;
      wake_r <= wake_nxt;
      settle_r <= settle_nxt;
      ready_r <= ready_nxt;
    end
  end

  ihp_pkg::ihp_width_e width; // access width
  logic dword_mode; // upper data lanes in use
  always_comb begin
    width = ihp_width(wake_r, eed_r);
    dword_mode = eed_r & ~wake_r;
    // full 10-bit compare equals the bit-by-bit select
    sel = ready_r & ~filt_r[`IHP_B_AEN] &
          ({filt_r[`IHP_B_ADDR_HI:`IHP_B_ADDR_LO], 4'h0} == ihp_io_base(base_r));
  end

  ////////////////////////////////////////////////////////////////////////
  // command sequencer

  ihp_pkg::ihp_state_e st_r, st_nxt; // sequencer state
  logic [7:0] idx_r, idx_nxt; // register index
  logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt; // write and read data
  logic isrd_r, isrd_nxt; // current command is a read
  logic rdp_r, rdp_nxt, wrp_r, wrp_nxt; // core strobes
  logic oe_r, oe_nxt; // host data drive
  always_comb begin
    st_nxt = st_r;
    idx_nxt = idx_r;
    wd_nxt = wd_r;
    rd_nxt = rd_r;
    isrd_nxt = isrd_r;
    rdp_nxt = 1'b0;
    wrp_nxt = 1'b0;
    case (st_r)
      ihp_pkg::IHP_IDLE: begin
        // read wins if both strobes show at once
        if (sel && strobe) begin
          isrd_nxt = rd_act;
          if (cmd_type_f()) begin
            rdp_nxt = rd_act;
            wrp_nxt = ~rd_act;
            wd_nxt = dword_mode ? hdata : {16'h0000, hdata[15:0]};
            st_nxt = ihp_pkg::IHP_BUSY;
          end else begin
            if (rd_act) begin
              rd_nxt = {24'h000000, idx_r};
            end else begin
              idx_nxt = hdata[7:0];
            end
            st_nxt = ihp_pkg::IHP_HOLD;
          end
        end
      end
      ihp_pkg::IHP_BUSY: begin
        // core raises busy the cycle after the strobe
        if (!reg_busy && !rdp_r && !wrp_r) begin
          if (isrd_r) begin
            rd_nxt = reg_rdata;
          end
          st_nxt = ihp_pkg::IHP_HOLD;
        end
      end
      ihp_pkg::IHP_HOLD: begin
        // one command per strobe; wait for release
        if (!strobe) begin
          st_nxt = ihp_pkg::IHP_IDLE;
        end
      end
      default: begin
        st_nxt = ihp_pkg::IHP_IDLE;
      end
    endcase
    if (hrst) begin
      st_nxt = ihp_pkg::IHP_IDLE;
      idx_nxt = 8'h00;
      rdp_nxt = 1'b0;
      wrp_nxt = 1'b0;
    end
    oe_nxt = (st_nxt == ihp_pkg::IHP_HOLD) && isrd_nxt;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= ihp_pkg::IHP_IDLE;
      idx_r <= 8'h00;
      wd_r <= 32'h00000000;
      rd_r <= 32'h00000000;
      isrd_r <= 1'b0;
      rdp_r <= 1'b0;
      wrp_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      idx_r <= idx_nxt;
      wd_r <= wd_nxt;
      rd_r <= rd_nxt;
      isrd_r <= isrd_nxt;
      rdp_r <= rdp_nxt;
      wrp_r <= wrp_nxt;
      oe_r <= oe_nxt;
    end
  end

  // command type pin, filtered
  function automatic logic cmd_type_f();
    cmd_type_f = filt_r[`IHP_B_CMD];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // indications and irq, registered

  logic wind_r, wind_nxt, dind_r, dind_nxt, irq_r, irq_nxt; // output flops
  always_comb begin
    // asserted level is low unless eeprom sets it high
    wind_nxt = ~ind_pol_high ^ (sel && cmd_type_f() && mem_port &&
               (width == ihp_pkg::IHP_W16 || width == ihp_pkg::IHP_W32));
    dind_nxt = ~ind_pol_high ^ (sel && cmd_type_f() && mem_port &&
               dword_mode && width == ihp_pkg::IHP_W32);
    irq_nxt = irq_in ^ (intlo_r ^ int_pol_flip);
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wind_r <= 1'b1;
      dind_r <= 1'b1;
      irq_r <= 1'b0;
    end else begin
      wind_r <= wind_nxt;
      dind_r <= dind_nxt;
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  always_comb begin
    // hold the host while a command is still pending
    cmd_ready = ~(sel && strobe && st_r == ihp_pkg::IHP_BUSY);
    host_data_low_o = rd_r[15:0];
    host_data_high_o = rd_r[31:16];
    host_data_low_oe = oe_r;
    host_data_high_oe = oe_r && dword_mode;
    word_access_ind_n = wind_r;
    dword_access_ind_n = dind_r;
    irq_out = irq_r;
    reg_index = idx_r;
    reg_rd = rdp_r;
    reg_wr = wrp_r;
    reg_wdata = wd_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_sel;
    @(posedge mclk) disable iff (!reset_n)
    sel |-> filt_r[`IHP_B_ADDR_HI -: 2] == 2'h3 && !filt_r[`IHP_B_ADDR_HI-2] &&
            filt_r[`IHP_B_ADDR_LO +: 3] == base_r && !filt_r[`IHP_B_AEN];
  endproperty
  a_sel: assert property (p_sel) else $error("select without match");
  property p_idx;
    @(posedge mclk) disable iff (!reset_n)
    !(st_r == ihp_pkg::IHP_IDLE && sel && wr_act && !rd_act && !cmd_type_f()) && !hrst
      |=> $stable(idx_r);
  endproperty
  a_idx: assert property (p_idx) else $error("index changed");
  property p_idxw;
    @(posedge mclk) disable iff (!reset_n)
    st_r == ihp_pkg::IHP_IDLE && sel && wr_act && !rd_act && !cmd_type_f() && !hrst
      |=> idx_r == $past(hdata[7:0]);
  endproperty
  a_idxw: assert property (p_idxw) else $error("index not written");
  property p_wrp;
    @(posedge mclk) disable iff (!reset_n)
    reg_wr |-> $past(filt_r[`IHP_B_CMD]) && $past(st_r) == ihp_pkg::IHP_IDLE ##1 !reg_wr;
  endproperty
  a_wrp: assert property (p_wrp) else $error("bad data write pulse");
  property p_rdy;
    @(posedge mclk) disable iff (!reset_n)
    !cmd_ready |=> !reg_wr && !reg_rd;
  endproperty
  a_rdy: assert property (p_rdy) else $error("ready while pending");
  property p_rst;
    @(posedge mclk) disable iff (!reset_n)
    hrst |=> st_r == ihp_pkg::IHP_IDLE && !ready_r && !reg_wr && !reg_rd;
  endproperty
  a_rst: assert property (p_rst) else $error("hw reset ignored");
  property p_pol;
    @(posedge mclk) disable iff (!reset_n)
    !strobe_pol_high && filt_r[`IHP_B_RD] && filt_r[`IHP_B_WR] &&
      st_r == ihp_pkg::IHP_IDLE |=> st_r == ihp_pkg::IHP_IDLE;
  endproperty
  a_pol: assert property (p_pol) else $error("high strobe taken");
  property p_irq;
    @(posedge mclk) disable iff (!reset_n)
    ##1 irq_out == ($past(irq_in) ^ $past(intlo_r) ^ $past(int_pol_flip));
  endproperty
  a_irq: assert property (p_irq) else $error("irq polarity wrong");
  property p_hi;
    @(posedge mclk) disable iff (!reset_n)
    host_data_high_oe |-> eed_r && !wake_r && host_data_low_oe;
  endproperty
  a_hi: assert property (p_hi) else $error("upper lanes outside dword");
  property p_dind;
    @(posedge mclk) disable iff (!reset_n)
    !ind_pol_high && !dword_access_ind_n |-> !word_access_ind_n &&
      width == ihp_pkg::IHP_W32;
  endproperty
  a_dind: assert property (p_dind) else $error("dword ind off width");
  property p_wind;
    @(posedge mclk) disable iff (!reset_n)
    $past(width) == ihp_pkg::IHP_W8 && !ind_pol_high |-> word_access_ind_n;
  endproperty
  a_wind: assert property (p_wind) else $error("word ind on byte");
  property p_wid;
    @(posedge mclk) disable iff (!reset_n)
    ready_r && !wake_r && eed_r |-> width == ihp_pkg::IHP_W32;
  endproperty
  a_wid: assert property (p_wid) else $error("width decode wrong");

  c_rd: cover property (@(posedge mclk) disable iff (!reset_n) reg_rd ##[1:20] host_data_low_oe);
  c_wr: cover property (@(posedge mclk) disable iff (!reset_n) reg_wr);
  c_wait: cover property (@(posedge mclk) disable iff (!reset_n) !cmd_ready);
  c_idx: cover property (@(posedge mclk) disable iff (!reset_n) $changed(idx_r));

endmodule

/* File: ihp_params.svh */
// Purpose: constants for the host port decode block
// Assumes: included by the package and by the design
// Notes: bit positions refer to the synchroniser vector
`ifndef IHP_PARAMS_SVH
`define IHP_PARAMS_SVH
`define IHP_SY_W 49
`define IHP_B_RD 32
`define IHP_B_WR 33
`define IHP_B_CMD 34
`define IHP_B_AEN 35
`define IHP_B_ADDR_LO 36
`define IHP_B_ADDR_HI 41
`define IHP_B_BASE_LO 42
`define IHP_B_BASE_HI 44
`define IHP_B_INTLO 45
`define IHP_B_EEDAT 46
`define IHP_B_WAKE 47
`define IHP_B_HWRST 48
`define IHP_SY_RST 49'h0_000B_0000_0000
`define IHP_IO_FIXED 10'h300
`define IHP_IO_STEP 10'h010
`define IHP_SETTLE 3'h4
`endif

/* File: ihp_pkg.sv */
// Purpose: types for the host port decode block
// Assumes: ihp_params.svh holds the numbers
// Notes: one-hot state codes
`include "ihp_params.svh"
package ihp_pkg;
  // port sequencer states
  typedef enum logic [2:0] {
    IHP_IDLE = 3'h1,
    IHP_BUSY = 3'h2,
    IHP_HOLD = 3'h4
  } ihp_state_e;
  // internal memory access width
  typedef enum logic [1:0] {
    IHP_W16 = 2'h0,
    IHP_W32 = 2'h1,
    IHP_W8 = 2'h2,
    IHP_WRSV = 2'h3
  } ihp_width_e;
endpackage

/* File: test_isa_style_host_port_decode.sv */
// Purpose: self-checking bench for the host port decode block
// Assumes: base strap 5 (port at 350h), dword mode, irq strap high
// Notes: a small core model answers reg_rd and reg_wr
`timescale 1ns/1ns
module test_isa_style_host_port_decode;
  logic mclk, reset_n, hw_reset, cmd_ready, wi_n, dwi_n, irq_out, irq_in;
  logic int_pol_flip, strobe_pol_high, mem_port, reg_rd, reg_wr, reg_busy;
  logic oe_lo, oe_hi, cmd_type, aq_n, rd_n, wr_n, word_seen, dword_seen;
  logic [5:0] upper_addr;
  logic [7:0] reg_index;
  logic [15:0] wlo, whi, rlo, rhi;
  logic [31:0] reg_wdata, reg_rdata, rdat, wdata_seen;
  int fail_count, cmp_count, busy_len, bcnt, rd_seen, wr_seen;
  ////////////////////////////////////////////////////////////////
  // design, host and clock
  ihp_host_port dut (.mclk(mclk), .reset_n(reset_n), .hw_reset(hw_reset),
    .base_strap(3'h5), .int_low_strap(1'b1), .eeprom_out_strap(1'b1),
    .wakeup_strap(1'b0), .upper_addr(upper_addr), .addr_qualify_n(aq_n),
    .cmd_type(cmd_type), .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n),
    .host_data_low_i(wlo), .host_data_low_o(rlo), .host_data_low_oe(oe_lo),
    .host_data_high_i(whi), .host_data_high_o(rhi), .host_data_high_oe(oe_hi),
    .cmd_ready(cmd_ready), .word_access_ind_n(wi_n), .dword_access_ind_n(dwi_n),
    .irq_out(irq_out), .strobe_pol_high(strobe_pol_high), .ind_pol_high(1'b0),
    .int_pol_flip(int_pol_flip), .reg_index(reg_index), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_busy(reg_busy), .mem_port(mem_port), .irq_in(irq_in));
  ihp_host_model host (.mclk(mclk), .pol_high(strobe_pol_high), .cmd_ready(cmd_ready),
    .rd_oe(oe_lo), .rd_lo(rlo), .rd_hi(rhi), .upper_addr(upper_addr),
    .addr_qualify_n(aq_n), .cmd_type(cmd_type), .rd_n(rd_n), .wr_n(wr_n),
    .wd_lo(wlo), .wd_hi(whi));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////
  // core model: busy for busy_len cycles after each pulse
  always @(posedge mclk) begin
    if (reg_wr === 1'b1) begin
      wr_seen <= wr_seen + 1;
      wdata_seen <= reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      rd_seen <= rd_seen + 1;
    end
    if (reg_rd === 1'b1 || reg_wr === 1'b1) begin
      bcnt <= busy_len;
      reg_busy <= 1'b1;
    end else begin
      bcnt <= (bcnt > 0) ? bcnt - 1 : 0;
      reg_busy <= (bcnt > 1);
    end
  end
  // indications seen while a memory read answers
  always @(negedge mclk) begin
    if (oe_lo === 1'b1 && mem_port) begin
      word_seen <= wi_n;
      dword_seen <= dwi_n;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // index write then index read back
  task automatic t_index();
    host.cycle(6'h35, 1'b0, 1'b0, 1'b0, 32'h0000_003C, rdat);
    check(reg_index, 8'h3C, "index");
    host.cycle(6'h35, 1'b0, 1'b0, 1'b1, 32'h0, rdat);
    check(rdat[15:0], 16'h003C, "index read");
    check(host.saw_wait, 1'b0, "no wait when idle");
  endtask
  // writes off the base address or unqualified are ignored
  task automatic t_select();
    logic [5:0] bad [5] = '{6'h15, 6'h25, 6'h3D, 6'h34, 6'h35};
    for (int i = 0; i < 5; i++) begin
      host.cycle(bad[i], (i == 4), 1'b0, 1'b0, 32'h0000_00E0 + i, rdat);
      check(reg_index, 8'h3C, "unselected");
    end
  endtask
  // data port read and write, both lane halves
  task automatic t_data();
    mem_port <= 1'b1;
    reg_rdata <= 32'hA5C3_1E87;
    host.cycle(6'h35, 1'b0, 1'b1, 1'b1, 32'h0, rdat);
    check(rdat, 32'hA5C3_1E87, "data read");
    check(rd_seen, 1, "read pulse");
    check(word_seen, 1'b0, "word ind");
    check(dword_seen, 1'b0, "dword ind");
    host.cycle(6'h35, 1'b0, 1'b1, 1'b0, 32'h5A3C_9617, rdat);
    check(wdata_seen, 32'h5A3C_9617, "data write");
    check(wr_seen, 1, "write pulse");
  endtask
  // a command is held until the core is no longer busy with it
  task automatic t_wait();
    busy_len = 40;
    host.cycle(6'h35, 1'b0, 1'b1, 1'b0, 32'h0000_1111, rdat);
    host.cycle(6'h35, 1'b0, 1'b1, 1'b0, 32'h2222_0000, rdat);
    check(host.saw_wait, 1'b1, "wait seen");
    check(wr_seen, 3, "held write done");
    busy_len = 3;
    repeat (50) @(posedge mclk);
  endtask
  // active-high strobes after the polarity flip
  task automatic t_pol();
    // deselect first: a flip turns idle strobe levels into active ones
    host.addr_qualify_n <= 1'b1;
    repeat (6) @(posedge mclk);
    strobe_pol_high <= 1'b1;
    repeat (10) @(posedge mclk);
    host.cycle(6'h35, 1'b0, 1'b0, 1'b0, 32'h0000_0077, rdat);
    check(reg_index, 8'h77, "high strobes");
    host.addr_qualify_n <= 1'b1;
    repeat (6) @(posedge mclk);
    strobe_pol_high <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  // irq polarity from strap and flip
  task automatic t_irq();
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      irq_in <= i[0];
      int_pol_flip <= i[1];
      repeat (8) @(negedge mclk);
      check(irq_out, i[0] ^ 1'b1 ^ i[1], "irq level");
    end
  endtask
  // hardware reset clears the index
  task automatic t_hwrst();
    @(posedge mclk);
    hw_reset <= 1'b1;
    repeat (10) @(posedge mclk);
    hw_reset <= 1'b0;
    repeat (20) @(negedge mclk);
    check(reg_index, 8'h00, "hw reset index");
    check(cmd_ready, 1'b1, "hw reset ready");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {fail_count, cmp_count, rd_seen, wr_seen, bcnt} = '0;
    busy_len = 3;
    {reset_n, hw_reset, irq_in, int_pol_flip, strobe_pol_high, mem_port} = '0;
    {reg_busy, word_seen, dword_seen} = 3'b111;
    reg_rdata = 32'h0;
    wdata_seen = 32'h0;
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (12) @(posedge mclk);
    t_index();
    t_select();
    t_data();
    t_wait();
    t_pol();
    t_irq();
    t_hwrst();
    summarize();
  end
  // watchdog sized well past the run
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
endmodule
